/* common/ufpc_pkg.sv */
// Constants shared by the processor-side buffer port control block.
// Assumes a 10 MHz AHB-Lite clock and word-aligned register slots.
package ufpc_pkg;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 12;
  localparam logic [11:0] IDX_CTRL = 12'h042;
  localparam logic [11:0] IDX_CFG = 12'h048;
  localparam logic [11:0] IDX_MPS = 12'h049;
  localparam logic [11:0] IDX_CMD = 12'h04a;
  localparam logic [11:0] IDX_ISTAT = 12'h04c;
  localparam logic [11:0] IDX_IMASK = 12'h04d;
  localparam int CTRL_DLY = 14;
  localparam int CTRL_VAL = 13;
  localparam int CTRL_CLR = 12;
  localparam int CTRL_NRDY = 11;
  localparam int CNT_W = 11;
  localparam logic [15:0] CTRL_RESET = 16'h0800;
  localparam int CFG_DIR = 0;
  localparam int CFG_DBL = 1;
  localparam int CFG_BYTE8 = 2;
  localparam int CFG_READ_COUNT_MODE = 3;
  localparam int CFG_W = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [10:0] MPS_RESET = 11'h040;
  localparam int CMD_TGL = 0;
  localparam int CMD_SIE_SIDE_CLEAR = 1;
  localparam int CMD_ALL_CLEAR = 2;
  localparam int CMD_RESEL = 3;
  localparam int IRQ_RXRDY = 0;
  localparam int IRQ_TXDONE = 1;
  localparam int IRQ_TXSTART = 2;
  localparam int IRQ_W = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int READY_TIME_NS = 200;
  localparam int READY_CYCLES_I = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] READY_CYCLES = READY_CYCLES_I[3:0];
  typedef enum logic [2:0] {
    ISO_OFF = 3'b001,
    ISO_WAIT_SOF = 3'b010,
    ISO_ARMED = 3'b100
  } ufpc_iso_e;
endpackage

/* src/ufpc_port_ctrl.sv */
// Control and status logic of the processor-side buffer port of a USB controller.
// Assumes SIE events and data-register strobes come from logic on hclk,
// and that this is the only slave on its AHB-Lite segment.
`timescale 1ns/10ps
module ufpc_port_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sie_rx_done,
  input wire logic [10:0] sie_rx_len,
  input wire logic sie_tx_done,
  input wire logic sie_sof,
  input wire logic sie_in_token,
  input wire logic cpu_data_read,
  input wire logic cpu_data_write,
  output logic data_access_en,
  output logic endpoint_buffer_ready_flag,
  output logic tx_start,
  output logic tx_zero_length,
  output logic [10:0] tx_length,
  output logic cpu_buf_clear,
  output logic cpu_buf_sel,
  output logic irq
);

  function automatic logic hit(input logic [11:0] idx, input logic [11:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction

  function automatic logic [10:0] step(input logic byte8);
    step = byte8 ? 11'h001 : 11'h002;
  endfunction

  // Bus state.
  logic wr_q;
  logic rd_q;
  logic [11:0] idx_q;
  logic next_wr;
  logic next_rd;
  logic [11:0] next_idx;
  logic [31:0] next_hrdata;

  // Core state.
  logic valid;
  logic sie_full;
  logic tx_active;
  ufpc_pkg::ufpc_iso_e iso_st;
  logic [10:0] rx_total;
  logic [10:0] rx_left;
  logic [10:0] sie_len;
  logic [10:0] tx_bytes;
  logic [10:0] cpu_len;
  logic [3:0] rdy_cnt;
  logic [3:0] cfg;
  logic [10:0] mps;
  logic [2:0] istat;
  logic [2:0] imask;

  logic next_valid;
  logic next_sie_full;
  logic next_tx_active;
  ufpc_pkg::ufpc_iso_e next_iso_st;
  logic [10:0] next_rx_total;
  logic [10:0] next_rx_left;
  logic [10:0] next_sie_len;
  logic [10:0] next_tx_bytes;
  logic [10:0] next_cpu_len;
  logic [3:0] next_rdy_cnt;
  logic [3:0] next_cfg;
  logic [10:0] next_mps;
  logic [2:0] next_istat;
  logic [2:0] next_imask;
  logic next_tx_start;
  logic next_tx_zero_length;
  logic [10:0] next_tx_length;
  logic next_cpu_buf_clear;
  logic next_cpu_buf_sel;

  logic nrdy;
  logic dir_in;
  logic dbl;
  logic [15:0] wdat;
  logic [10:0] cnt_view;

  assign nrdy = (rdy_cnt != 4'h0);
  assign dir_in = cfg[ufpc_pkg::CFG_DIR];
  assign dbl = cfg[ufpc_pkg::CFG_DBL];
  assign wdat = hwdata[15:0];
  assign cnt_view = cfg[ufpc_pkg::CFG_READ_COUNT_MODE] ? rx_left : rx_total;
  assign data_access_en = !nrdy;
  assign endpoint_buffer_ready_flag = valid;
  assign irq = |(istat & imask);
  assign hreadyout = !rd_q;
  assign hresp = 1'b0;

  // Address phase capture; reads take one wait state so that a write in the
  // preceding data phase is already visible in the returned word.
  always_comb begin
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_idx = idx_q;
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready) begin
      next_wr = hwrite;
      next_rd = !hwrite;
      next_idx = haddr[ufpc_pkg::ADDR_LSB +: ufpc_pkg::IDX_W];
    end
    if (rd_q) begin
      next_hrdata = 32'h0000_0000;
      if (hit(idx_q, ufpc_pkg::IDX_CTRL)) begin
        next_hrdata[ufpc_pkg::CTRL_DLY] = (iso_st != ufpc_pkg::ISO_OFF);
        next_hrdata[ufpc_pkg::CTRL_VAL] = valid && !nrdy;
        next_hrdata[ufpc_pkg::CTRL_NRDY] = nrdy;
        // Buffer clear always reads zero.
        next_hrdata[ufpc_pkg::CNT_W-1:0] = nrdy ? 11'h000 : cnt_view;
      end else if (hit(idx_q, ufpc_pkg::IDX_CFG)) begin
        next_hrdata[ufpc_pkg::CFG_W-1:0] = cfg;
      end else if (hit(idx_q, ufpc_pkg::IDX_MPS)) begin
        next_hrdata[10:0] = mps;
      end else if (hit(idx_q, ufpc_pkg::IDX_ISTAT)) begin
        next_hrdata[ufpc_pkg::IRQ_W-1:0] = istat;
      end else if (hit(idx_q, ufpc_pkg::IDX_IMASK)) begin
        next_hrdata[ufpc_pkg::IRQ_W-1:0] = imask;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_q <= next_wr;
      rd_q <= next_rd;
      idx_q <= next_idx;
      hrdata <= next_hrdata;
    end
  end

  // Buffer flags, counts and transmit scheduling.
  always_comb begin
    logic we_ctrl;
    logic we_cmd;
    logic w_val;
    logic w_clr;
    logic w_dly;
    logic c_tgl;
    logic c_sie_side_clear;
    logic c_all_clear;
    logic rd_ok;
    logic wr_ok;
    logic complete;
    logic swap;
    logic pend;
    logic [10:0] sum;
    logic [2:0] ev;
    logic [2:0] w1c;
    we_ctrl = wr_q && hit(idx_q, ufpc_pkg::IDX_CTRL);
    we_cmd = wr_q && hit(idx_q, ufpc_pkg::IDX_CMD);
    w_val = we_ctrl && wdat[ufpc_pkg::CTRL_VAL];
    w_clr = we_ctrl && wdat[ufpc_pkg::CTRL_CLR];
    w_dly = we_ctrl && wdat[ufpc_pkg::CTRL_DLY];
    c_tgl = we_cmd && wdat[ufpc_pkg::CMD_TGL];
    c_sie_side_clear = we_cmd && wdat[ufpc_pkg::CMD_SIE_SIDE_CLEAR];
    c_all_clear = we_cmd && wdat[ufpc_pkg::CMD_ALL_CLEAR];
    rd_ok = cpu_data_read && !nrdy && valid;
    wr_ok = cpu_data_write && !nrdy && !valid;
    complete = 1'b0;
    swap = 1'b0;
    pend = 1'b0;
    sum = 11'h000;
    w1c = 3'h0;
    ev = 3'h0;
    next_valid = valid;
    next_sie_full = sie_full;
    next_tx_active = tx_active;
    next_iso_st = iso_st;
    next_rx_total = rx_total;
    next_rx_left = rx_left;
    next_sie_len = sie_len;
    next_tx_bytes = tx_bytes;
    next_cpu_len = cpu_len;
    next_rdy_cnt = nrdy ? rdy_cnt - 4'h1 : rdy_cnt;
    next_cfg = cfg;
    next_mps = mps;
    next_imask = imask;
    next_tx_start = 1'b0;
    next_tx_zero_length = tx_zero_length;
    next_tx_length = tx_length;
    next_cpu_buf_clear = 1'b0;
    next_cpu_buf_sel = cpu_buf_sel;
    if (wr_q && hit(idx_q, ufpc_pkg::IDX_CFG)) begin
      next_cfg = wdat[ufpc_pkg::CFG_W-1:0];
    end
    if (wr_q && hit(idx_q, ufpc_pkg::IDX_MPS)) begin
      next_mps = wdat[10:0];
    end
    if (wr_q && hit(idx_q, ufpc_pkg::IDX_IMASK)) begin
      next_imask = wdat[ufpc_pkg::IRQ_W-1:0];
    end
    if (wr_q && hit(idx_q, ufpc_pkg::IDX_ISTAT)) begin
      w1c = wdat[ufpc_pkg::IRQ_W-1:0];
    end
    if (we_cmd && wdat[ufpc_pkg::CMD_RESEL]) begin
      next_rdy_cnt = ufpc_pkg::READY_CYCLES;
    end
    if (!dir_in) begin
      if (rd_ok) begin
        if (rx_left <= step(cfg[ufpc_pkg::CFG_BYTE8])) begin
          next_rx_left = 11'h000;
          next_rx_total = 11'h000;
          next_valid = 1'b0;
        end else begin
          next_rx_left = rx_left - step(cfg[ufpc_pkg::CFG_BYTE8]);
        end
      end
      if (w_clr && valid) begin
        next_cpu_buf_clear = 1'b1;
        next_valid = 1'b0;
        next_rx_left = 11'h000;
        next_rx_total = 11'h000;
      end
      if (c_all_clear) begin
        next_valid = 1'b0;
        next_sie_full = 1'b0;
        next_rx_left = 11'h000;
        next_rx_total = 11'h000;
      end
      if (sie_rx_done) begin
        if (!dbl) begin
          next_valid = 1'b1;
          next_rx_total = sie_rx_len;
          next_rx_left = sie_rx_len;
        end else begin
          next_sie_full = 1'b1;
          next_sie_len = sie_rx_len;
        end
      end
      if (c_tgl) begin
        next_valid = 1'b1;
      end
      if (dbl && next_sie_full && !next_valid) begin
        next_valid = 1'b1;
        next_rx_total = next_sie_len;
        next_rx_left = next_sie_len;
        next_sie_full = 1'b0;
        next_cpu_buf_sel = !cpu_buf_sel;
      end
    end else begin
      // A clear with valid written alongside still empties the buffer first.
      if (w_clr && (!valid || w_val || dbl)) begin
        next_cpu_buf_clear = 1'b1;
        next_tx_bytes = 11'h000;
        if (dbl) begin
          next_valid = 1'b0;
        end
      end
      if (wr_ok) begin
        sum = tx_bytes + step(cfg[ufpc_pkg::CFG_BYTE8]);
        next_tx_bytes = sum;
        complete = (sum >= mps);
      end
      if (w_val || w_dly) begin
        complete = 1'b1;
      end
      if (w_dly) begin
        next_iso_st = ufpc_pkg::ISO_WAIT_SOF;
      end
      if (complete) begin
        next_valid = 1'b1;
        next_cpu_len = next_tx_bytes;
        if (!dbl) begin
          next_tx_length = next_tx_bytes;
          next_tx_zero_length = (next_tx_bytes == 11'h000);
        end
      end
      if (sie_tx_done) begin
        next_tx_active = 1'b0;
        if (!dbl) begin
          next_valid = 1'b0;
          next_tx_bytes = 11'h000;
        end else begin
          next_sie_full = 1'b0;
        end
      end
      if (c_sie_side_clear || c_all_clear) begin
        next_valid = 1'b0;
        next_sie_full = 1'b0;
      end
      if (c_all_clear) begin
        next_tx_bytes = 11'h000;
        next_iso_st = ufpc_pkg::ISO_OFF;
      end
      swap = dbl && next_valid && !next_sie_full;
      if (swap) begin
        next_sie_full = 1'b1;
        next_valid = 1'b0;
        next_tx_bytes = 11'h000;
        next_tx_length = next_cpu_len;
        next_tx_zero_length = (next_cpu_len == 11'h000);
        next_cpu_buf_sel = !cpu_buf_sel;
      end
      pend = dbl ? sie_full : valid;
      if (sie_in_token && pend && !tx_active) begin
        if (iso_st == ufpc_pkg::ISO_OFF) begin
          next_tx_start = 1'b1;
        end else if (iso_st == ufpc_pkg::ISO_ARMED) begin
          next_tx_start = 1'b1;
          next_iso_st = ufpc_pkg::ISO_OFF;
        end
      end
      if (iso_st == ufpc_pkg::ISO_WAIT_SOF && sie_sof && !w_dly) begin
        next_iso_st = ufpc_pkg::ISO_ARMED;
      end
      if (next_tx_start) begin
        next_tx_active = 1'b1;
      end
    end
    ev[ufpc_pkg::IRQ_RXRDY] = !valid && next_valid && !dir_in;
    ev[ufpc_pkg::IRQ_TXDONE] = sie_tx_done && dir_in;
    ev[ufpc_pkg::IRQ_TXSTART] = next_tx_start;
    // A new event wins over a clear in the same cycle.
    next_istat = (istat & ~w1c) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid <= ufpc_pkg::CTRL_RESET[ufpc_pkg::CTRL_VAL];
      sie_full <= 1'b0;
      tx_active <= 1'b0;
      iso_st <= ufpc_pkg::ISO_OFF;
      rx_total <= 11'h000;
      rx_left <= 11'h000;
      sie_len <= 11'h000;
      tx_bytes <= 11'h000;
      cpu_len <= 11'h000;
      rdy_cnt <= ufpc_pkg::READY_CYCLES;
      cfg <= ufpc_pkg::CFG_RESET;
      mps <= ufpc_pkg::MPS_RESET;
      istat <= 3'h0;
      imask <= 3'h0;
      tx_start <= 1'b0;
      tx_zero_length <= 1'b0;
      tx_length <= 11'h000;
      cpu_buf_clear <= 1'b0;
      cpu_buf_sel <= 1'b0;
    end else begin
      valid <= next_valid;
      sie_full <= next_sie_full;
      tx_active <= next_tx_active;
      iso_st <= next_iso_st;
      rx_total <= next_rx_total;
      rx_left <= next_rx_left;
      sie_len <= next_sie_len;
      tx_bytes <= next_tx_bytes;
      cpu_len <= next_cpu_len;
      rdy_cnt <= next_rdy_cnt;
      cfg <= next_cfg;
      mps <= next_mps;
      istat <= next_istat;
      imask <= next_imask;
      tx_start <= next_tx_start;
      tx_zero_length <= next_tx_zero_length;
      tx_length <= next_tx_length;
      cpu_buf_clear <= next_cpu_buf_clear;
      cpu_buf_sel <= next_cpu_buf_sel;
    end
  end

endmodule

/* test/ufpc_port_ctrl_assertions.sv */
// Concurrent checks on the ports of the buffer port control block.
// Assumes a single hclk domain with hresetn as asynchronous active-low reset.
`timescale 1ns/10ps
module ufpc_port_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sie_in_token,
  input wire logic tx_start,
  input wire logic tx_zero_length,
  input wire logic [10:0] tx_length,
  input wire logic cpu_buf_clear,
  input wire logic data_access_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_req; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr_req; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
  property p_rd; s_rd_req |=> s_rd_ans; endproperty
  property p_wr; s_wr_req |=> hreadyout; endproperty
  property p_resp; hresp == 1'b0; endproperty
  property p_tok; tx_start |-> $past(sie_in_token); endproperty
  property p_txp; tx_start |=> !tx_start; endproperty
  property p_clr; cpu_buf_clear |=> !cpu_buf_clear; endproperty
  property p_zlp; tx_start && tx_zero_length |-> tx_length == 11'h000; endproperty
  property p_rdy; $rose(data_access_en) |-> $past(data_access_en, 2) == 1'b0; endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  a_wr: assert property (p_wr) else $error("write was stalled");
  a_resp: assert property (p_resp) else $error("response not OKAY");
  a_tok: assert property (p_tok) else $error("transmit start without IN token");
  a_txp: assert property (p_txp) else $error("transmit start longer than a cycle");
  a_clr: assert property (p_clr) else $error("buffer clear did not drop");
  a_zlp: assert property (p_zlp) else $error("zero length packet has a length");
  a_rdy: assert property (p_rdy) else $error("port ready too early");
endmodule
bind ufpc_port_ctrl ufpc_port_ctrl_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sie_in_token(sie_in_token), .tx_start(tx_start), .tx_zero_length(tx_zero_length),
  .tx_length(tx_length), .cpu_buf_clear(cpu_buf_clear), .data_access_en(data_access_en));

/* test/ufpc_sie_model.sv */
// Serial engine side model: reports transmit done after a set latency.
// Assumes tx_start is a one-cycle pulse on hclk.
`timescale 1ns/10ps
module ufpc_sie_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_start,
  input wire logic [3:0] lat,
  output logic sie_tx_done
);
  logic [4:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 5'h00;
      sie_tx_done <= 1'b0;
    end else begin
      sie_tx_done <= (cnt == 5'h01);
      if (tx_start) begin
        cnt <= {1'b0, lat} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

/* test/ufpc_port_ctrl_test.sv */
// Self-checking bench for the buffer port control block.
// Assumes the block is the only slave, so hready is its own hreadyout.
`timescale 1ns/10ps
module ufpc_port_ctrl_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, tx_done, tx_start, tx_zl;
  logic dae, flag, clr, bsel, clr_seen, ts_zl;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [10:0] rx_len, tx_length, ts_len;
  logic [4:0] strb;
  logic [3:0] lat;
  int failures, samples_checked, cycles, ts_cnt, n;
  function automatic logic [31:0] fa(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  ufpc_port_ctrl i_ufpc_port_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sie_rx_done(strb[0]),
    .sie_rx_len(rx_len), .sie_tx_done(tx_done), .sie_sof(strb[1]), .sie_in_token(strb[2]),
    .cpu_data_read(strb[3]), .cpu_data_write(strb[4]), .data_access_en(dae),
    .endpoint_buffer_ready_flag(flag), .tx_start(tx_start), .tx_zero_length(tx_zl),
    .tx_length(tx_length), .cpu_buf_clear(clr), .cpu_buf_sel(bsel), .irq(irq));
  ufpc_sie_model i_ufpc_sie_model (.hclk(hclk), .hresetn(hresetn), .tx_start(tx_start),
    .lat(lat), .sie_tx_done(tx_done));
  task finish_test;
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task sb(input int b);
    @(posedge hclk);
    strb[b] <= 1'b1;
    @(posedge hclk);
    strb <= 5'h00;
  endtask
  task tok;
    sb(2);
    repeat (3) @(posedge hclk);
  endtask
  task wait_idle;
    while (flag !== 1'b0) @(posedge hclk);
  endtask
  task t_reset;
    while (dae !== 1'b1) @(posedge hclk);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h0);
    rdc("mps", fa(ufpc_pkg::IDX_MPS), 32'h40);
    rdc("hole", 32'h200, 32'h0);
  endtask
  task t_out;
    ahb(1'b1, fa(ufpc_pkg::IDX_CFG), 32'h8);
    rx_len <= 11'd4;
    sb(0);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2004);
    chk("ready flag", flag, 1);
    sb(3);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2002);
    sb(3);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("ready flag", flag, 0);
    ahb(1'b1, fa(ufpc_pkg::IDX_CFG), 32'h4);
    rx_len <= 11'd2;
    sb(0);
    sb(3);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2002);
    sb(3);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h0);
    rx_len <= 11'd3;
    sb(0);
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2003);
    clr_seen <= 1'b0;
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h1000);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("clear pulse", clr_seen, 1);
    ahb(1'b1, fa(ufpc_pkg::IDX_CMD), 32'h1);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2000);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("valid", rd & 32'h2000, 32'h2000);
    ahb(1'b1, fa(ufpc_pkg::IDX_CMD), 32'h8);
    @(negedge hclk);
    chk("access enable", dae, 0);
    while (dae !== 1'b1) @(posedge hclk);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2000);
    ahb(1'b1, fa(ufpc_pkg::IDX_CMD), 32'h4);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("valid", rd & 32'h2000, 32'h0);
  endtask
  task t_dbl;
    ahb(1'b1, fa(ufpc_pkg::IDX_CFG), 32'h6);
    rx_len <= 11'd2;
    sb(0);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2002);
    chk("buffer select", bsel, 1);
    rx_len <= 11'd3;
    sb(0);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2002);
    chk("buffer select", bsel, 1);
    sb(3);
    sb(3);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h2003);
    chk("buffer select", bsel, 0);
    ahb(1'b1, fa(ufpc_pkg::IDX_CMD), 32'h4);
    rdc("ctrl", fa(ufpc_pkg::IDX_CTRL), 32'h0);
  endtask
  task t_in;
    ahb(1'b1, fa(ufpc_pkg::IDX_CFG), 32'h1);
    ahb(1'b1, fa(ufpc_pkg::IDX_MPS), 32'h4);
    sb(4);
    sb(4);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("valid", rd & 32'h2000, 32'h2000);
    tok;
    chk("tx length", ts_len, 4);
    chk("zero length", ts_zl, 0);
    wait_idle;
    chk("ready flag", flag, 0);
    ahb(1'b1, fa(ufpc_pkg::IDX_IMASK), 32'h2);
    @(negedge hclk);
    chk("irq", irq, 1);
    ahb(1'b1, fa(ufpc_pkg::IDX_ISTAT), 32'h7);
    @(negedge hclk);
    chk("irq", irq, 0);
    sb(4);
    sb(4);
    ahb(1'b1, fa(ufpc_pkg::IDX_CMD), 32'h2);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("valid", rd & 32'h2000, 32'h0);
    clr_seen <= 1'b0;
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h1000);
    lat <= 4'h0;
    sb(4);
    chk("clear pulse", clr_seen, 1);
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h2000);
    tok;
    chk("tx length", ts_len, 2);
    wait_idle;
    lat <= 4'h6;
    clr_seen <= 1'b0;
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h3000);
    tok;
    chk("zero length", ts_zl, 1);
    chk("clear pulse", clr_seen, 1);
    chk("ready flag", flag, 1);
    wait_idle;
    sb(4);
    ahb(1'b1, fa(ufpc_pkg::IDX_CTRL), 32'h4000);
    n = ts_cnt;
    tok;
    chk("tx count", ts_cnt, n);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("delay bit", rd & 32'h4000, 32'h4000);
    sb(1);
    tok;
    chk("tx count", ts_cnt, n + 1);
    ahb(1'b0, fa(ufpc_pkg::IDX_CTRL), 32'h0);
    chk("delay bit", rd & 32'h4000, 32'h0);
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (tx_start === 1'b1) begin
      ts_cnt <= ts_cnt + 1;
      ts_len <= tx_length;
      ts_zl <= tx_zl;
    end
    if (clr === 1'b1) clr_seen <= 1'b1;
    if (cycles == 20000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    strb = 5'h00;
    rx_len = 11'h000;
    lat = 4'h3;
    clr_seen = 1'b0;
    repeat (2) @(posedge hclk);
    chk("access enable", dae, 0);
    hresetn <= 1'b1;
    t_reset;
    t_out;
    t_dbl;
    t_in;
    finish_test;
  end
endmodule
